//--- include/crt_raster_pkg.sv
// Constants, field layout and carrier types of the raster timing core
// Functional notes
// - Line total register holds characters minus five
// - Character counter steps per character clock
// - Display enable lasts end value plus one
// - Horizontal blanking starts at blank begin count
// - Skew field delays display enable 0-3
// - Blanking ends on six-bit end match
// - Horizontal retrace starts at sync begin count
// - Retrace delay field skews retrace 0-3 character clocks
// - Retrace ends on five-bit end field match
// - Ten-bit vertical total is lines minus two
// - High-bits register extends vertical values
// - Row height register holds bit nine extras
// - Row counter loads preset at vertical retrace start
// - Row counter clears at maximum, not preset
// - Start captured at vertical retrace start
// - Double scan halves row counter clock
// - Row height field is rows minus one
// - Cursor disable bit suppresses cursor
// - Cursor first row field gives start row
// - No cursor when start exceeds end
// - Index port then data port, base selectable
// - Protect bit blocks writes to indexes 0-7, except the line compare bit of index 7
package crt_raster_pkg;

	// Register index space
	localparam int IDX_W = 5;
	localparam int REG_COUNT = 25;
	localparam logic [IDX_W-1:0] IDX_HTOTAL = 5'h00;
	localparam logic [IDX_W-1:0] IDX_HACTIVE_END = 5'h01;
	localparam logic [IDX_W-1:0] IDX_HBLANK_BEGIN = 5'h02;
	localparam logic [IDX_W-1:0] IDX_HBLANK_FINISH = 5'h03;
	localparam logic [IDX_W-1:0] IDX_HSYNC_BEGIN = 5'h04;
	localparam logic [IDX_W-1:0] IDX_HSYNC_FINISH = 5'h05;
	localparam logic [IDX_W-1:0] IDX_VTOTAL = 5'h06;
	localparam logic [IDX_W-1:0] IDX_VHIGH = 5'h07;
	localparam logic [IDX_W-1:0] IDX_ROW_PRESET = 5'h08;
	localparam logic [IDX_W-1:0] IDX_ROW_HEIGHT = 5'h09;
	localparam logic [IDX_W-1:0] IDX_CURSOR_TOP = 5'h0a;
	localparam logic [IDX_W-1:0] IDX_CURSOR_BOTTOM = 5'h0b;
	localparam logic [IDX_W-1:0] IDX_VSYNC_BEGIN = 5'h10;
	localparam logic [IDX_W-1:0] IDX_VSYNC_FINISH = 5'h11;
	localparam logic [IDX_W-1:0] IDX_VACTIVE_END = 5'h12;
	localparam logic [IDX_W-1:0] IDX_VBLANK_BEGIN = 5'h15;
	localparam logic [IDX_W-1:0] IDX_VBLANK_FINISH = 5'h16;
	localparam logic [IDX_W-1:0] IDX_LINE_CMP = 5'h18;

	// I/O port bases, index port at base, data port at base plus one
	localparam logic [15:0] IO_BASE_COLOR = 16'h03d4;
	localparam logic [15:0] IO_BASE_MONO = 16'h03b4;
	localparam logic [15:0] IO_DATA_STEP = 16'h0001;

	// Field positions
	localparam int SKEW_LSB = 5;
	localparam int END_BLANK_TOP_POS = 7;
	localparam int RETRACE_DELAY_LSB = 5;
	localparam int PROTECT_POS = 7;
	localparam int VTOTAL8_POS = 0;
	localparam int VACTIVE8_POS = 1;
	localparam int VSYNC8_POS = 2;
	localparam int VBLANK8_POS = 3;
	localparam int LINE_CMP8_POS = 4;
	localparam int VTOTAL9_POS = 5;
	localparam int VACTIVE9_POS = 6;
	localparam int VSYNC9_POS = 7;
	localparam int VBLANK9_POS = 5;
	localparam int LINE_CMP9_POS = 6;
	localparam int DOUBLE_SCAN_POS = 7;
	localparam int CURSOR_OFF_POS = 5;
	localparam int ROW_W = 5;

	// Offsets between programmed values and last counts
	localparam logic [8:0] HTOTAL_ADJ = 9'h004;
	localparam logic [10:0] VTOTAL_ADJ = 11'h001;

	// Reset value of every timing register and of the read latch
	localparam logic [7:0] REG_RESET = 8'h00;

	// Writable bits per register class
	localparam logic [7:0] MASK_ALL = 8'hff;
	localparam logic [7:0] MASK_PRESET = 8'h7f;
	localparam logic [7:0] MASK_CURSOR = 8'h3f;
	localparam logic [7:0] MASK_LINE_CMP8 = 8'h10;

	// Host I/O cycle
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} io_req_t;

	// Raster signals toward the monitor side
	typedef struct packed {
		logic hsync;
		logic vsync;
		logic hblank;
		logic vblank;
		logic disp_en;
	} raster_t;

endpackage

//--- rtl/crt_raster_timing_core.sv
// Raster timing core: indexed registers, counters, blanking, retrace and cursor rows
`timescale 1ns/1ps
module crt_raster_timing_core
	import crt_raster_pkg::*;
#(
	parameter int CHAR_DIV = 8 // System clocks per character clock
)(
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire io_req_t io_req_i,
	input wire logic io_select_i,
	output logic [7:0] io_rdata_o,
	output raster_t raster_o,
	output logic [ROW_W-1:0] row_scan_o,
	output logic cursor_row_o,
	output logic frame_latch_o
);

	localparam int DIV_W = (CHAR_DIV > 1) ? $clog2(CHAR_DIV) : 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CHAR_DIV - 1);

	// Refuse a divider the counter cannot serve
	initial
	begin
		if (CHAR_DIV < 1 || CHAR_DIV > 256)
			$error("CHAR_DIV must lie in 1..256");
	end

	// Whole state of the block
	typedef struct packed {
		logic [IDX_W-1:0] idx; // Index port
		logic [REG_COUNT-1:0][7:0] regs; // Timing registers
		logic [7:0] rdata; // Read latch
		logic [DIV_W-1:0] div; // Character clock divider
		logic tick; // Character clock enable
		logic [7:0] hcnt; // Character counter
		logic [9:0] vcnt; // Line counter
		logic [ROW_W-1:0] row; // Row scan counter
		logic dbl_phase; // Double scan line parity
		logic hblank; // Horizontal blanking
		logic hsync_raw; // Retrace before delay
		logic hsync; // Retrace after delay
		logic [2:0] hs_pipe; // Retrace delay line
		logic [2:0] de_pipe; // Display enable skew line
		logic disp_en; // Skewed display enable
		logic vblank; // Vertical blanking
		logic vsync; // Vertical retrace
		logic cursor; // Cursor on this row
		logic frame; // Start of vertical retrace
	} state_t;

	state_t s_q;
	state_t s_d;

	// Registers that exist behind the data port
	function automatic logic reg_valid(input logic [IDX_W-1:0] i);
		unique case (i)
			IDX_HTOTAL, IDX_HACTIVE_END, IDX_HBLANK_BEGIN, IDX_HBLANK_FINISH,
			IDX_HSYNC_BEGIN, IDX_HSYNC_FINISH, IDX_VTOTAL, IDX_VHIGH,
			IDX_ROW_PRESET, IDX_ROW_HEIGHT, IDX_CURSOR_TOP, IDX_CURSOR_BOTTOM,
			IDX_VSYNC_BEGIN, IDX_VSYNC_FINISH, IDX_VACTIVE_END,
			IDX_VBLANK_BEGIN, IDX_VBLANK_FINISH, IDX_LINE_CMP: reg_valid = 1'b1;
			default: reg_valid = 1'b0;
		endcase
	endfunction

	// Bits that take part in a write; reserved bits stay zero
	function automatic logic [7:0] write_mask(input logic [IDX_W-1:0] i);
		unique case (i)
			IDX_ROW_PRESET: write_mask = MASK_PRESET;
			IDX_CURSOR_TOP, IDX_CURSOR_BOTTOM: write_mask = MASK_CURSOR;
			default: write_mask = MASK_ALL;
		endcase
	endfunction

	// Port decode
	logic [15:0] io_base;
	logic idx_hit;
	logic data_hit;
	logic protect;
	logic low_idx;
	assign io_base = io_select_i ? IO_BASE_COLOR : IO_BASE_MONO;
	assign idx_hit = io_req_i.addr == io_base;
	assign data_hit = io_req_i.addr == 16'(io_base + IO_DATA_STEP);
	assign protect = s_q.regs[IDX_VSYNC_FINISH][PROTECT_POS];
	assign low_idx = s_q.idx <= IDX_VHIGH;

	// Register fields in use by the timing logic
	logic [7:0] htot;
	logic [7:0] hde_end;
	logic [7:0] hbb;
	logic [5:0] hbe;
	logic [1:0] de_skew;
	logic [7:0] hsb;
	logic [1:0] hs_delay;
	logic [4:0] hse;
	logic [9:0] vtot;
	logic [9:0] vde_end;
	logic [9:0] vsb;
	logic [3:0] vse;
	logic [9:0] vbb;
	logic [7:0] vbe;
	logic [ROW_W-1:0] row_preset;
	logic [ROW_W-1:0] row_max;
	logic dbl_scan;
	logic cur_off;
	logic [ROW_W-1:0] cur_top;
	logic [ROW_W-1:0] cur_bot;
	logic [7:0] hi;
	assign hi = s_q.regs[IDX_VHIGH];
	assign htot = s_q.regs[IDX_HTOTAL];
	assign hde_end = s_q.regs[IDX_HACTIVE_END];
	assign hbb = s_q.regs[IDX_HBLANK_BEGIN];
	// Six-bit blank end split over two registers
	assign hbe = {s_q.regs[IDX_HSYNC_FINISH][END_BLANK_TOP_POS],
		s_q.regs[IDX_HBLANK_FINISH][4:0]};
	assign de_skew = s_q.regs[IDX_HBLANK_FINISH][SKEW_LSB+:2];
	assign hsb = s_q.regs[IDX_HSYNC_BEGIN];
	assign hs_delay = s_q.regs[IDX_HSYNC_FINISH][RETRACE_DELAY_LSB+:2];
	assign hse = s_q.regs[IDX_HSYNC_FINISH][4:0];
	// Ten-bit vertical values from the high-bits registers
	assign vtot = {hi[VTOTAL9_POS], hi[VTOTAL8_POS], s_q.regs[IDX_VTOTAL]};
	assign vde_end = {hi[VACTIVE9_POS], hi[VACTIVE8_POS], s_q.regs[IDX_VACTIVE_END]};
	assign vsb = {hi[VSYNC9_POS], hi[VSYNC8_POS], s_q.regs[IDX_VSYNC_BEGIN]};
	assign vbb = {s_q.regs[IDX_ROW_HEIGHT][VBLANK9_POS], hi[VBLANK8_POS],
		s_q.regs[IDX_VBLANK_BEGIN]};
	assign vse = s_q.regs[IDX_VSYNC_FINISH][3:0];
	assign vbe = s_q.regs[IDX_VBLANK_FINISH];
	assign row_preset = s_q.regs[IDX_ROW_PRESET][ROW_W-1:0];
	assign row_max = s_q.regs[IDX_ROW_HEIGHT][ROW_W-1:0];
	assign dbl_scan = s_q.regs[IDX_ROW_HEIGHT][DOUBLE_SCAN_POS];
	assign cur_off = s_q.regs[IDX_CURSOR_TOP][CURSOR_OFF_POS];
	assign cur_top = s_q.regs[IDX_CURSOR_TOP][ROW_W-1:0];
	assign cur_bot = s_q.regs[IDX_CURSOR_BOTTOM][ROW_W-1:0];

	// Counter decodes
	logic h_last;
	logic v_last;
	logic [9:0] v_next;
	logic de_now;
	logic row_step;
	// Last character of the line is total register plus four
	assign h_last = {1'b0, s_q.hcnt} == 9'({1'b0, htot} + HTOTAL_ADJ);
	// Last line of the frame is total register plus one
	assign v_last = {1'b0, s_q.vcnt} == 11'({1'b0, vtot} + VTOTAL_ADJ);
	assign v_next = v_last ? 10'h000 : 10'(s_q.vcnt + 10'h001);
	// Active through count equal to the end value, so end plus one chars
	assign de_now = (s_q.hcnt <= hde_end) && (s_q.vcnt <= vde_end);
	// Double scan lets the row counter step every second line
	assign row_step = !dbl_scan || s_q.dbl_phase;

	// Next state
	always_comb
	begin
		s_d = s_q;
		s_d.frame = 1'b0;
		// Character clock enable from the system clock
		s_d.tick = s_q.div == DIV_LAST;
		s_d.div = s_d.tick ? '0 : DIV_W'(s_q.div + 1'b1);

		// Index port write
		if (io_req_i.wr && idx_hit)
			s_d.idx = io_req_i.wdata[IDX_W-1:0];
		// Data port write; protection spares the line compare bit
		if (io_req_i.wr && data_hit && reg_valid(s_q.idx))
		begin
			if (protect && low_idx)
			begin
				// Only the line compare high bit survives protection
				if (s_q.idx == IDX_VHIGH)
					s_d.regs[IDX_VHIGH] = (hi & ~MASK_LINE_CMP8)
						| (io_req_i.wdata & MASK_LINE_CMP8);
			end
			else
				s_d.regs[s_q.idx] = io_req_i.wdata & write_mask(s_q.idx);
		end
		// Read latch; unlisted indexes read zero
		if (io_req_i.rd && idx_hit)
			s_d.rdata = 8'({s_q.idx});
		else if (io_req_i.rd && data_hit)
			s_d.rdata = reg_valid(s_q.idx) ? s_q.regs[s_q.idx] : REG_RESET;

		// Horizontal timing on each character clock
		if (s_q.tick)
		begin
			s_d.hcnt = h_last ? 8'h00 : 8'(s_q.hcnt + 8'h01);
			// Start wins if both compares hit together
			if (s_q.hcnt == hbb)
				s_d.hblank = 1'b1;
			else if (s_q.hcnt[5:0] == hbe)
				s_d.hblank = 1'b0;
			if (s_q.hcnt == hsb)
				s_d.hsync_raw = 1'b1;
			else if (s_q.hcnt[4:0] == hse)
				s_d.hsync_raw = 1'b0;
			// Retrace delay line
			s_d.hs_pipe = {s_q.hs_pipe[1:0], s_q.hsync_raw};
			// Zero delay takes the fresh compare, so retrace lines up with blanking
			if (hs_delay == 2'b00)
				s_d.hsync = s_d.hsync_raw;
			else if (hs_delay == 2'b01)
				s_d.hsync = s_q.hsync_raw;
			else
				s_d.hsync = s_q.hs_pipe[hs_delay[0]];
			// Display enable skew line
			s_d.de_pipe = {s_q.de_pipe[1:0], de_now};
			s_d.disp_en = (de_skew == 2'b00) ? de_now : s_q.de_pipe[de_skew - 2'b01];

			// Vertical timing once per completed line
			if (h_last)
			begin
				s_d.vcnt = v_next;
				if (v_next == vbb)
					s_d.vblank = 1'b1;
				else if (v_next[7:0] == vbe)
					s_d.vblank = 1'b0;
				if (v_next == vsb)
				begin
					// Retrace start captures the frame and presets the row
					s_d.vsync = 1'b1;
					s_d.frame = 1'b1;
					s_d.row = row_preset;
					s_d.dbl_phase = 1'b0;
				end
				else
				begin
					if (v_next[3:0] == vse)
						s_d.vsync = 1'b0;
					s_d.dbl_phase = dbl_scan && !s_q.dbl_phase;
					if (row_step)
						// Cleared at the maximum, never reloaded
						s_d.row = (s_q.row == row_max) ? '0 : ROW_W'(s_q.row + 1'b1);
				end
			end
		end

		// Cursor rows; empty when disabled or start past end
		s_d.cursor = !cur_off && (cur_top <= cur_bot)
			&& (s_q.row >= cur_top) && (s_q.row <= cur_bot);
	end

	// State register with synchronous reset
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_b_i)
		begin
			s_q <= '0;
			for (int i = 0; i < REG_COUNT; i++)
				s_q.regs[i] <= REG_RESET;
		end
		else
			s_q <= s_d;
	end

	// Outputs straight from the state register
	assign io_rdata_o = s_q.rdata;
	assign raster_o.hsync = s_q.hsync;
	assign raster_o.vsync = s_q.vsync;
	assign raster_o.hblank = s_q.hblank;
	assign raster_o.vblank = s_q.vblank;
	assign raster_o.disp_en = s_q.disp_en;
	assign row_scan_o = s_q.row;
	assign cursor_row_o = s_q.cursor;
	assign frame_latch_o = s_q.frame;

	// Checks on the timing behaviour
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	chk_hcnt_wrap: assert property (s_q.tick && h_last |=> s_q.hcnt == 8'h00)
		else $error("character counter did not wrap at line total");
	chk_hcnt_step: assert property (s_q.tick && !h_last
		|=> s_q.hcnt == 8'($past(s_q.hcnt) + 8'h01))
		else $error("character counter missed a step");
	chk_line_len: assert property (s_q.tick && $stable(htot)
		&& {1'b0, s_q.hcnt} <= 9'({1'b0, htot} + HTOTAL_ADJ)
		|=> {1'b0, s_q.hcnt} <= 9'({1'b0, $past(htot)} + HTOTAL_ADJ))
		else $error("line length check failed");
	chk_hblank_set: assert property (s_q.tick && s_q.hcnt == hbb |=> s_q.hblank)
		else $error("horizontal blanking did not start");
	chk_hblank_end: assert property (s_q.tick && s_q.hcnt != hbb && s_q.hcnt[5:0] == hbe
		|=> !s_q.hblank)
		else $error("horizontal blanking did not end on six-bit match");
	chk_hsync_end: assert property (s_q.tick && s_q.hcnt != hsb && s_q.hcnt[4:0] == hse
		|=> !s_q.hsync_raw)
		else $error("retrace did not end on five-bit match");
	chk_de_noskew: assert property (s_q.tick && de_skew == 2'b00
		|=> s_q.disp_en == $past(de_now))
		else $error("display enable wrong without skew");
	chk_de_skew: assert property (s_q.tick && de_skew == 2'b01 && $stable(de_skew)
		|=> s_q.disp_en == $past(s_q.de_pipe[0]))
		else $error("display enable not skewed by one character");
	chk_hs_delay: assert property (s_q.tick && hs_delay == 2'b10
		|=> s_q.hsync == $past(s_q.hs_pipe[0]))
		else $error("retrace not delayed by two characters");
	chk_vcnt_wrap: assert property (s_q.tick && h_last && v_last |=> s_q.vcnt == 10'h000)
		else $error("line counter did not wrap at vertical total");
	chk_row_preset: assert property (s_q.frame |-> s_q.row == $past(row_preset))
		else $error("row counter not preset at vertical retrace");
	chk_row_clear: assert property (s_q.tick && h_last && v_next != vsb && row_step
		&& s_q.row == row_max |=> s_q.row == '0)
		else $error("row counter not cleared at maximum");
	chk_row_hold: assert property (s_q.tick && h_last && v_next != vsb && !row_step
		|=> $stable(s_q.row))
		else $error("row counter stepped on skipped double scan line");
	chk_cursor_off: assert property (cur_off |=> !s_q.cursor)
		else $error("cursor shown while disabled");
	chk_cursor_empty: assert property (cur_top > cur_bot |=> !s_q.cursor)
		else $error("cursor shown with start past end");
	chk_protect: assert property (io_req_i.wr && data_hit && protect && low_idx
		&& s_q.idx != IDX_VHIGH |=> s_q.regs == $past(s_q.regs))
		else $error("protected register was written");
	chk_frame_vsync: assert property (s_q.frame |-> s_q.vsync)
		else $error("frame latch without vertical retrace");

	cov_frame_wrap: cover property (s_q.tick && h_last && v_last);
	cov_cursor_row: cover property (s_q.cursor ##1 !s_q.cursor);
	cov_protected_write: cover property (io_req_i.wr && data_hit && protect && low_idx);
	cov_double_scan: cover property (dbl_scan && s_q.tick && h_last && !row_step);

endmodule

//--- verif/raster_monitor.sv
// Raster monitor model: measures line, blanking, retrace and frame timing
`timescale 1ns/1ps
module raster_monitor
	import crt_raster_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire raster_t raster_i,
	output logic [9:0] line_clks_o,
	output logic [9:0] hb_fall_o,
	output logic [9:0] hs_rise_o,
	output logic [9:0] hs_fall_o,
	output logic [9:0] de_rise_o,
	output logic [9:0] de_fall_o,
	output logic [9:0] frame_lines_o,
	output logic [9:0] vs_lines_o
);
	raster_t prev_q; // Levels seen at the last edge
	logic [9:0] clk_cnt_q; // Clocks since blanking went active
	logic [9:0] line_cnt_q; // Lines since vertical retrace went active
	logic [9:0] cur; // Offset of this edge from blanking start

	// Offset restarts on the rising edge of blanking
	always_comb
	begin
		cur = (raster_i.hblank && !prev_q.hblank) ? 10'h000 : 10'(clk_cnt_q + 10'h001);
	end

	// Locks on blanking start, the way a tube locks on its line; purely passive
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_b_i)
		begin
			prev_q <= '0;
			clk_cnt_q <= '0;
			line_cnt_q <= '0;
		end
		else
		begin
			prev_q <= raster_i;
			clk_cnt_q <= cur;
			// Line period and line count
			if (raster_i.hblank && !prev_q.hblank)
			begin
				line_clks_o <= clk_cnt_q + 10'h001;
				line_cnt_q <= line_cnt_q + 10'h001;
			end
			// Edges timed from blanking start
			if (!raster_i.hblank && prev_q.hblank)
				hb_fall_o <= cur;
			if (raster_i.hsync && !prev_q.hsync)
				hs_rise_o <= cur;
			if (!raster_i.hsync && prev_q.hsync)
				hs_fall_o <= cur;
			if (raster_i.disp_en && !prev_q.disp_en)
				de_rise_o <= cur;
			if (!raster_i.disp_en && prev_q.disp_en)
				de_fall_o <= cur;
			// Frame length and vertical retrace width in lines
			if (raster_i.vsync && !prev_q.vsync)
			begin
				frame_lines_o <= line_cnt_q;
				line_cnt_q <= '0;
			end
			if (!raster_i.vsync && prev_q.vsync)
				vs_lines_o <= line_cnt_q;
		end
	end
endmodule

//--- verif/tb.sv
// Self-checking bench of the raster timing core
`timescale 1ns/1ps
module tb;
	import crt_raster_pkg::*;
	localparam int LINE = 16; // Line total 0x0b plus five characters
	// Index, written byte, expected read
	localparam logic [7:0] ROWS [16][3] = '{
		'{8'h00, 8'h0b, 8'h0b}, '{8'h01, 8'h09, 8'h09}, '{8'h02, 8'h0a, 8'h0a},
		'{8'h04, 8'h0b, 8'h0b}, '{8'h05, 8'h0d, 8'h0d}, '{8'h06, 8'h06, 8'h06},
		'{8'h07, 8'h00, 8'h00}, '{8'h08, 8'h81, 8'h01}, '{8'h09, 8'h02, 8'h02},
		'{8'h0a, 8'hc1, 8'h01}, '{8'h0b, 8'h02, 8'h02}, '{8'h10, 8'h05, 8'h05},
		'{8'h11, 8'h07, 8'h07}, '{8'h12, 8'h04, 8'h04}, '{8'h15, 8'h05, 8'h05},
		'{8'h0c, 8'h5a, 8'h00}};
	// Cursor top per row pass: shown, disabled, start past end, double scan
	localparam logic [7:0] CUR_TOP [4] = '{8'h01, 8'h21, 8'h03, 8'h01};
	logic sys_clk_i;
	logic rst_b_i;
	io_req_t io_req_i;
	logic io_select_i;
	logic [7:0] io_rdata_o;
	raster_t raster_o;
	logic [ROW_W-1:0] row_scan_o;
	logic cursor_row_o;
	logic frame_latch_o;
	logic [9:0] line_clks, hb_fall, hs_rise, hs_fall, de_rise, de_fall, frame_lines, vs_lines;
	logic [15:0] base; // Index port address in use
	logic [7:0] rd_val; // Last data port read
	int n_mismatch;
	int samples_checked;

	// One character per clock keeps frames short
	crt_raster_timing_core #(.CHAR_DIV(1)) dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.io_req_i(io_req_i), .io_select_i(io_select_i), .io_rdata_o(io_rdata_o),
		.raster_o(raster_o), .row_scan_o(row_scan_o), .cursor_row_o(cursor_row_o),
		.frame_latch_o(frame_latch_o));

	raster_monitor mon (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .raster_i(raster_o),
		.line_clks_o(line_clks), .hb_fall_o(hb_fall), .hs_rise_o(hs_rise),
		.hs_fall_o(hs_fall), .de_rise_o(de_rise), .de_fall_o(de_fall),
		.frame_lines_o(frame_lines), .vs_lines_o(vs_lines));

	// 100 MHz clock
	initial
	begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// Counted compare
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One port access held across one rising edge, then an idle cycle
	task automatic io_cyc(input logic [15:0] a, input logic w, input logic [7:0] d);
		@(negedge sys_clk_i);
		io_req_i = '{addr: a, wr: w, rd: !w, wdata: d};
		@(negedge sys_clk_i);
		io_req_i = '0;
	endtask

	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
		io_cyc(base, 1'b1, idx);
		io_cyc(base + IO_DATA_STEP, 1'b1, d);
	endtask

	task automatic rd_reg(input logic [7:0] idx);
		io_cyc(base, 1'b1, idx);
		io_cyc(base + IO_DATA_STEP, 1'b0, 8'h00);
		rd_val = io_rdata_o;
	endtask

	// Bounded wait for the start address capture pulse
	task automatic wait_latch();
		int i;
		for (i = 0; i < 6000; i++)
		begin
			@(negedge sys_clk_i);
			if (frame_latch_o === 1'b1)
				break;
		end
		if (i == 6000)
		begin
			n_mismatch++;
			$display("Error at %0t: no frame capture pulse", $time);
			end_of_test();
		end
	endtask

	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		int v;
		int k;
		int nchg;
		logic [4:0] r;
		logic [4:0] rp;
		n_mismatch = 0;
		samples_checked = 0;
		io_req_i = '0;
		io_select_i = 1'b1;
		base = IO_BASE_COLOR;
		rst_b_i = 1'b0;
		repeat (10) @(negedge sys_clk_i);
		check(raster_o, 10'h000);
		check(frame_latch_o, 10'h000);
		rst_b_i = 1'b1;
		rd_reg(8'h04);
		check(rd_val, 8'h00);
		// Register table: write, read back, reserved bits and unlisted index
		for (v = 0; v < 16; v++)
		begin
			wr_reg(ROWS[v][0], ROWS[v][1]);
			rd_reg(ROWS[v][0]);
			check(rd_val, ROWS[v][2]);
		end
		io_cyc(base, 1'b0, 8'h00);
		check(io_rdata_o, 8'h0c);
		// Skew and retrace delay, blank end is begin 10 plus width 4
		for (v = 0; v < 4; v++)
		begin
			wr_reg(8'h03, {1'b1, 2'(v), 5'h0e});
			wr_reg(8'h05, {1'b0, 2'(v), 5'h0d});
			wait_latch();
			wait_latch();
			check(line_clks, 10'(LINE));
			check(hb_fall, 10'h004);
			check(hs_rise, 10'(1 + v));
			check(hs_fall, 10'(3 + v));
			check(de_rise, 10'(6 + v));
			check(de_fall, 10'(v));
		end
		check(frame_lines, 10'd8);
		check(vs_lines, 10'd2);
		// Vertical total bit 8 from the high-bits register
		wr_reg(8'h07, 8'h01);
		wait_latch();
		wait_latch();
		wr_reg(8'h07, 8'h00);
		check(frame_lines, 10'd264);
		// Row counter, cursor rows and double scan
		for (v = 0; v < 4; v++)
		begin
			wr_reg(8'h0a, CUR_TOP[v]);
			wr_reg(8'h09, (v == 3) ? 8'h82 : 8'h02);
			wait_latch();
			wait_latch();
			check(raster_o.vsync, 10'h001);
			check(row_scan_o, 10'h001);
			@(negedge sys_clk_i);
			check(frame_latch_o, 10'h000);
			repeat (7) @(negedge sys_clk_i);
			nchg = 0;
			rp = '0;
			for (k = 0; k < 5; k++)
			begin
				r = row_scan_o;
				if (k > 0 && r !== rp)
					nchg++;
				if (v < 3)
				begin
					check(r, 10'((k + 1) % 3));
					check(cursor_row_o, 10'((v == 0) && ((k + 1) % 3 != 0)));
				end
				rp = r;
				repeat (LINE) @(negedge sys_clk_i);
			end
			check(10'(nchg), (v == 3) ? 10'd2 : 10'd4);
		end
		// Protected writes, line compare bit still writable
		wr_reg(8'h11, 8'h87);
		wr_reg(8'h00, 8'hff);
		rd_reg(8'h00);
		check(rd_val, 8'h0b);
		wr_reg(8'h07, 8'hff);
		rd_reg(8'h07);
		check(rd_val, 8'h10);
		wr_reg(8'h11, 8'h07);
		// Alternate port pair; the other pair is then ignored
		io_select_i = 1'b0;
		base = IO_BASE_MONO;
		wr_reg(8'h01, 8'h07);
		rd_reg(8'h01);
		check(rd_val, 8'h07);
		base = IO_BASE_COLOR;
		wr_reg(8'h01, 8'h05);
		base = IO_BASE_MONO;
		rd_reg(8'h01);
		check(rd_val, 8'h07);
		end_of_test();
	end
endmodule
